// ---- design/relay_out_defs.vh ----
`ifndef RELAY_OUT_DEFS_VH
`define RELAY_OUT_DEFS_VH

// Register byte offsets.
`define REG_CTRL        8'h00
`define REG_LEVEL       8'h04
`define REG_LOWER       8'h08
`define REG_UPPER       8'h0c
`define REG_HYST        8'h10
`define REG_ON_DELAY    8'h14
`define REG_OFF_DELAY   8'h18
`define REG_MIN_ON      8'h1c
`define REG_MIN_OFF     8'h20
`define REG_STATUS      8'h24
`define REG_CHAN_INFO   8'h28
`define REG_LIST_COUNT  8'h2c
`define REG_OUT_VALUE   8'h30

// Control register fields.
`define CTRL_MODE_LSB   0
`define CTRL_MODE_MSB   2
`define CTRL_ALARM_LSB  4
`define CTRL_ALARM_MSB  6
`define CTRL_ACTIVE_BIT 8

// Status register fields.
`define STAT_STATE_BIT  0
`define STAT_REQ_BIT    1
`define STAT_ALARM_BIT  2
`define STAT_PEND_BIT   3

// Operating selections.
`define MODE_DISABLED   3'h0
`define MODE_ABOVE      3'h1
`define MODE_BELOW      3'h2
`define MODE_INSIDE     3'h3
`define MODE_OUTSIDE    3'h4

// Alarm reactions.
`define ALARM_HOLD      3'h0
`define ALARM_IMM_OFF   3'h1
`define ALARM_IMM_ON    3'h2
`define ALARM_TIMED_OFF 3'h3
`define ALARM_TIMED_ON  3'h4

// Reset values.
`define RST_CTRL        16'h0000
`define RST_HALF        16'h0000

// Encoded output states.
`define OUT_LOW_VALUE   16'h0000
`define OUT_HIGH_VALUE  16'hffff

// Timing base: one millisecond tick at the system clock rate.
`define CLK_FREQ_HZ     125000000
`define TICK_TIME_US    1000
`define TICK_CYCLES     ((`CLK_FREQ_HZ / 1000000) * `TICK_TIME_US)

`endif

// ---- design/threshold_relay_output.v ----
// Overview of operation
// - Disabled selection: output held low, no evaluation.
// - Above selection: high when source exceeds level.
// - Below selection: high when source under level.
// - Inside selection: high between lower and upper.
// - Outside selection: high outside lower and upper.
// - Hysteresis offsets both sides of thresholds.
// - Error or range flags enter alarm condition.
// - Hold reaction: output unchanged during alarm.
// - Immediate-off reaction forces low at once.
// - Immediate-on reaction forces high at once.
// - Low to high waits on-delay.
// - High to low waits off-delay.
// - High state held for minimum on-time.
// - Low state held for minimum off-time.
// - Low encodes zero, high encodes full scale.
// - Active but disabled channel sends zero.
// - Channel count follows configuration, else empty.
// - Port, slave and channel info read-only.
//
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "relay_out_defs.vh"

module threshold_relay_output #(
    parameter integer TICK_CYCLES   = `TICK_CYCLES, // Clock cycles per millisecond tick.
    parameter [7:0]   CHANNEL_COUNT = 8'h01,        // Channels defined by the bus master setup.
    parameter [7:0]   COMM_PORT     = 8'h01,        // Field-bus port number.
    parameter [7:0]   SLAVE_ADDR    = 8'h01,        // Remote slave address.
    parameter [7:0]   CHANNEL_NUM   = 8'h01,        // Remote output channel number.
    parameter [3:0]   REG_TYPE      = 4'h0,         // Remote register type code.
    parameter [3:0]   DATA_FORMAT   = 4'h0          // Remote data format code.
) (
    input  wire        clk_i,                     // System clock, 125 MHz.
    input  wire        rst_n_i,                   // Synchronous reset, active low.
    input  wire        cyc_i,                     // Wishbone cycle.
    input  wire        stb_i,                     // Wishbone strobe.
    input  wire        we_i,                      // Wishbone write enable.
    input  wire [7:0]  adr_i,                     // Wishbone byte address.
    input  wire [3:0]  sel_i,                     // Wishbone byte selects.
    input  wire [31:0] dat_i,                     // Wishbone write data.
    output reg  [31:0] dat_o,                     // Wishbone read data.
    output reg         ack_o,                     // Wishbone acknowledge.
    input  wire        source_valid_i,            // New source sample pulse.
    input  wire [15:0] source_value_i,            // Source sample value.
    input  wire        source_error_i,            // Source error indication.
    input  wire        source_over_range_flag_i,  // Source over-range indication.
    input  wire        source_under_range_flag_i, // Source under-range indication.
    output reg         out_state_o,               // Current output state.
    output reg  [15:0] out_value_o,               // Encoded value for the remote slave.
    output reg         out_valid_o                // Pulse: out_value_o is to be sent.
);

    localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

    // =========================================================================
    // Register file
    // =========================================================================
    reg  [15:0] ctrl_reg;
    reg  [15:0] level_reg;
    reg  [15:0] lower_reg;
    reg  [15:0] upper_reg;
    reg  [15:0] hyst_reg;
    reg  [15:0] on_delay_reg;
    reg  [15:0] off_delay_reg;
    reg  [15:0] min_on_reg;
    reg  [15:0] min_off_reg;

    wire [2:0]  mode      = ctrl_reg[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
    wire [2:0]  reaction  = ctrl_reg[`CTRL_ALARM_MSB:`CTRL_ALARM_LSB];
    wire        active    = ctrl_reg[`CTRL_ACTIVE_BIT];
    wire        wb_req    = cyc_i & stb_i & ~ack_o;
    wire        wb_wr     = wb_req & we_i;

    // Merges the selected low byte lanes of write data into a 16-bit field.
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] wdat;
        input [3:0]  sel;
        begin
            merge16 = {sel[1] ? wdat[15:8] : old[15:8], sel[0] ? wdat[7:0] : old[7:0]};
        end
    endfunction

    always @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_reg      <= `RST_CTRL;
            level_reg     <= `RST_HALF;
            lower_reg     <= `RST_HALF;
            upper_reg     <= `RST_HALF;
            hyst_reg      <= `RST_HALF;
            on_delay_reg  <= `RST_HALF;
            off_delay_reg <= `RST_HALF;
            min_on_reg    <= `RST_HALF;
            min_off_reg   <= `RST_HALF;
        end
        else if (wb_wr)
        begin
            case (adr_i)
                `REG_CTRL:      ctrl_reg      <= merge16(ctrl_reg, dat_i, sel_i);
                `REG_LEVEL:     level_reg     <= merge16(level_reg, dat_i, sel_i);
                `REG_LOWER:     lower_reg     <= merge16(lower_reg, dat_i, sel_i);
                `REG_UPPER:     upper_reg     <= merge16(upper_reg, dat_i, sel_i);
                `REG_HYST:      hyst_reg      <= merge16(hyst_reg, dat_i, sel_i);
                `REG_ON_DELAY:  on_delay_reg  <= merge16(on_delay_reg, dat_i, sel_i);
                `REG_OFF_DELAY: off_delay_reg <= merge16(off_delay_reg, dat_i, sel_i);
                `REG_MIN_ON:    min_on_reg    <= merge16(min_on_reg, dat_i, sel_i);
                `REG_MIN_OFF:   min_off_reg   <= merge16(min_off_reg, dat_i, sel_i);
                default:        ctrl_reg      <= ctrl_reg;
            endcase
        end
    end

    // =========================================================================
    // Millisecond tick
    // =========================================================================
    reg  [31:0] tick_cnt_reg;
    wire        tick = (tick_cnt_reg == TICK_LAST);

    always @(posedge clk_i)
    begin
        if (!rst_n_i)
            tick_cnt_reg <= 32'h0000_0000;
        else if (tick)
            tick_cnt_reg <= 32'h0000_0000;
        else
            tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end

    // =========================================================================
    // Threshold evaluation with hysteresis
    // =========================================================================
    // Thresholds are widened to 18 signed bits so offsets never wrap.
    wire signed [17:0] src_s   = {2'b00, source_value_i};
    wire signed [17:0] hyst_s  = {2'b00, hyst_reg};
    wire signed [17:0] lvl_top = {2'b00, level_reg} + hyst_s;
    wire signed [17:0] lvl_bot = {2'b00, level_reg} - hyst_s;
    wire signed [17:0] lwr_top = {2'b00, lower_reg} + hyst_s;
    wire signed [17:0] lwr_bot = {2'b00, lower_reg} - hyst_s;
    wire signed [17:0] upp_top = {2'b00, upper_reg} + hyst_s;
    wire signed [17:0] upp_bot = {2'b00, upper_reg} - hyst_s;

    reg  req_reg;
    reg  req_next;
    reg  alarm_reg;
    wire alarm_in = source_error_i | source_over_range_flag_i | source_under_range_flag_i;

    always @*
    begin
        req_next = req_reg;
        case (mode)
            `MODE_ABOVE:
            begin
                if (src_s > lvl_top)
                    req_next = 1'b1;
                else if (src_s < lvl_bot)
                    req_next = 1'b0;
            end
            `MODE_BELOW:
            begin
                if (src_s < lvl_bot)
                    req_next = 1'b1;
                else if (src_s > lvl_top)
                    req_next = 1'b0;
            end
            `MODE_INSIDE:
            begin
                if (src_s > lwr_top && src_s < upp_bot)
                    req_next = 1'b1;
                else if (src_s < lwr_bot || src_s > upp_top)
                    req_next = 1'b0;
            end
            `MODE_OUTSIDE:
            begin
                if (src_s < lwr_bot || src_s > upp_top)
                    req_next = 1'b1;
                else if (src_s > lwr_top && src_s < upp_bot)
                    req_next = 1'b0;
            end
            default:
                req_next = 1'b0;
        endcase
    end

    always @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            req_reg   <= 1'b0;
            alarm_reg <= 1'b0;
        end
        else if (mode == `MODE_DISABLED)
        begin
            req_reg   <= 1'b0;
            alarm_reg <= 1'b0;
        end
        else if (source_valid_i)
        begin
            alarm_reg <= alarm_in;
            if (!alarm_in)
                req_reg <= req_next;
        end
    end

    // =========================================================================
    // Target selection under alarm
    // =========================================================================
    reg state_reg;
    reg target;
    reg force_now;

    always @*
    begin
        target    = req_reg;
        force_now = 1'b0;
        if (alarm_reg)
        begin
            case (reaction)
                `ALARM_IMM_OFF:
                begin
                    target    = 1'b0;
                    force_now = 1'b1;
                end
                `ALARM_IMM_ON:
                begin
                    target    = 1'b1;
                    force_now = 1'b1;
                end
                `ALARM_TIMED_OFF:
                    target = 1'b0;
                `ALARM_TIMED_ON:
                    target = 1'b1;
                default:
                    target = state_reg;
            endcase
        end
    end

    // =========================================================================
    // Switching delays and minimum hold times
    // =========================================================================
    reg  [15:0] pend_cnt_reg;
    reg  [15:0] hold_cnt_reg;
    reg         last_target_reg;
    wire        pending   = (target != state_reg);
    wire [15:0] delay_sel = target ? on_delay_reg : off_delay_reg;
    wire [15:0] hold_sel  = state_reg ? min_on_reg : min_off_reg;
    wire        delay_ok  = (pend_cnt_reg >= delay_sel);
    wire        hold_ok   = (hold_cnt_reg >= hold_sel);
    wire        do_switch = pending & (force_now | (delay_ok & hold_ok));

    always @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            state_reg       <= 1'b0;
            pend_cnt_reg    <= 16'h0000;
            hold_cnt_reg    <= 16'h0000;
            last_target_reg <= 1'b0;
        end
        else if (mode == `MODE_DISABLED)
        begin
            state_reg       <= 1'b0;
            pend_cnt_reg    <= 16'h0000;
            hold_cnt_reg    <= 16'h0000;
            last_target_reg <= 1'b0;
        end
        else
        begin
            last_target_reg <= target;
            if (do_switch)
            begin
                state_reg    <= target;
                hold_cnt_reg <= 16'h0000;
                pend_cnt_reg <= 16'h0000;
            end
            else
            begin
                if (tick && hold_cnt_reg != 16'hffff)
                    hold_cnt_reg <= hold_cnt_reg + 16'h0001;
                // A new request restarts its delay; a held one keeps counting.
                if (!pending || target != last_target_reg)
                    pend_cnt_reg <= 16'h0000;
                else if (tick && pend_cnt_reg != 16'hffff)
                    pend_cnt_reg <= pend_cnt_reg + 16'h0001;
            end
        end
    end

    // =========================================================================
    // Encoded output toward the remote slave
    // =========================================================================
    reg state_d_reg;

    always @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            out_state_o <= 1'b0;
            out_value_o <= `OUT_LOW_VALUE;
            out_valid_o <= 1'b0;
            state_d_reg <= 1'b0;
        end
        else
        begin
            state_d_reg <= state_reg;
            out_state_o <= state_reg;
            if (mode == `MODE_DISABLED)
                out_value_o <= `OUT_LOW_VALUE;
            else
                out_value_o <= state_reg ? `OUT_HIGH_VALUE : `OUT_LOW_VALUE;
            // When active with a nonzero channel count, a value is sent per source sample and on every state change.
            out_valid_o <= active & (CHANNEL_COUNT != 8'h00) &
                           (source_valid_i | (state_reg != state_d_reg));
        end
    end

    // =========================================================================
    // Wishbone read path and acknowledge
    // =========================================================================
    wire [7:0] list_count = active ? CHANNEL_COUNT : 8'h00;

    always @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end
        else
        begin
            ack_o <= wb_req;
            if (wb_req && !we_i)
            begin
                case (adr_i)
                    `REG_CTRL:       dat_o <= {16'h0000, ctrl_reg};
                    `REG_LEVEL:      dat_o <= {16'h0000, level_reg};
                    `REG_LOWER:      dat_o <= {16'h0000, lower_reg};
                    `REG_UPPER:      dat_o <= {16'h0000, upper_reg};
                    `REG_HYST:       dat_o <= {16'h0000, hyst_reg};
                    `REG_ON_DELAY:   dat_o <= {16'h0000, on_delay_reg};
                    `REG_OFF_DELAY:  dat_o <= {16'h0000, off_delay_reg};
                    `REG_MIN_ON:     dat_o <= {16'h0000, min_on_reg};
                    `REG_MIN_OFF:    dat_o <= {16'h0000, min_off_reg};
                    `REG_STATUS:     dat_o <= {28'h0000000, pending, alarm_reg, req_reg, state_reg};
                    `REG_CHAN_INFO:  dat_o <= {DATA_FORMAT, REG_TYPE, CHANNEL_NUM, SLAVE_ADDR, COMM_PORT};
                    `REG_LIST_COUNT: dat_o <= {24'h000000, list_count};
                    `REG_OUT_VALUE:  dat_o <= {16'h0000, out_value_o};
                    default:         dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule // threshold_relay_output

// ---- dv/relay_slave_model.sv ----
`timescale 1ns/1ps
// ============================================================
// Remote slave: keeps the last value and counts the frames.
module relay_slave_model (
    input  wire        clk_i,         // System clock.
    input  wire        rst_n_i,       // Reset, active low.
    input  wire        valid_i,       // Frame strobe.
    input  wire [15:0] value_i,       // Frame value.
    output reg  [15:0] last_value_o,  // Last value received.
    output reg  [15:0] frame_count_o  // Frames received.
);
    always @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            last_value_o  <= 16'h0000;
            frame_count_o <= 16'h0000;
        end
        else if (valid_i)
        begin
            last_value_o  <= value_i;
            frame_count_o <= frame_count_o + 16'h0001;
        end
    end
endmodule // relay_slave_model

// ---- dv/threshold_relay_output_asserts.sv ----
`timescale 1ns/1ps
// ============================================================
module threshold_relay_output_asserts (
    input wire        clk_i,          // Clock.
    input wire        rst_n_i,        // Reset, active low.
    input wire        cyc_i,          // Cycle.
    input wire        stb_i,          // Strobe.
    input wire        we_i,           // Write enable.
    input wire [7:0]  adr_i,          // Address.
    input wire [31:0] dat_o,          // Read data.
    input wire        ack_o,          // Acknowledge.
    input wire        source_valid_i, // Sample pulse.
    input wire        out_state_o,    // Output state.
    input wire [15:0] out_value_o,    // Encoded value.
    input wire        out_valid_o     // Send pulse.
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_ack_follows_req:
        assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
    a_ack_single_pulse:
        assert property (ack_o |=> !ack_o) else $error("ack too long");
    a_ack_has_cause:
        assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
    a_read_upper_zero:
        assert property (ack_o && !we_i && adr_i != 8'h28 |-> dat_o[31:16] == 16'h0000) else $error("upper bits set");
    a_unmapped_zero:
        assert property (ack_o && !we_i && adr_i > 8'h30 |-> dat_o == 32'h0) else $error("unmapped read");
    a_value_encoding:
        assert property (out_value_o == (out_state_o ? 16'hffff : 16'h0000)) else $error("bad encoding");
    a_change_sends:
        assert property ($changed(out_state_o) |-> out_valid_o) else $error("change not sent");
    a_send_has_cause:
        assert property (out_valid_o |-> $past(source_valid_i) || $changed(out_state_o))
        else $error("send without cause");
endmodule // threshold_relay_output_asserts

bind threshold_relay_output threshold_relay_output_asserts chk_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .source_valid_i(source_valid_i),
    .out_state_o(out_state_o), .out_value_o(out_value_o), .out_valid_o(out_valid_o)
);

// ---- dv/test_threshold_relay_output.sv ----
`timescale 1ns/1ps
`include "relay_out_defs.vh"
module test_threshold_relay_output;
    reg         clk_i, rst_n_i, cyc_i, stb_i, we_i, src_valid, err, over, under;
    reg  [7:0]  adr_i;
    reg  [3:0]  sel, wsel;
    reg  [31:0] dat_i, q;
    reg  [15:0] src_value, e;
    wire [31:0] dat_o;
    wire        ack_o, out_state_o, out_valid_o;
    wire [15:0] out_value_o, last_value, frames;
    integer     err_count, checks, i, n;
    // Entries {mode, expected, value}; alarm entries {reaction, start, flags, expected}.
    localparam [95:0] MODE_TBL  = {16'h4064, 16'h41c8, 16'h30c8, 16'h3164, 16'h2065, 16'h2163};
    localparam [79:0] ALARM_TBL = {16'h4011, 16'h3110, 16'h2041, 16'h1120, 16'h0111};

    threshold_relay_output #(.TICK_CYCLES(4), .CHANNEL_COUNT(8'h03), .SLAVE_ADDR(8'h07),
        .REG_TYPE(4'h3), .DATA_FORMAT(4'h2)) dut_u (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .source_valid_i(src_valid),
        .source_value_i(src_value), .source_error_i(err), .source_over_range_flag_i(over),
        .source_under_range_flag_i(under), .out_state_o(out_state_o), .out_value_o(out_value_o),
        .out_valid_o(out_valid_o));
    relay_slave_model slave_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .valid_i(out_valid_o),
        .value_i(out_value_o), .last_value_o(last_value), .frame_count_o(frames));

    task end_sim;
        if (err_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        checks = checks + 1;
        if (seen !== exp)
        begin
            err_count = err_count + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // ============================================================
    // Wishbone classic single cycle; read data is taken at the ack edge.
    task wb(input w, input [7:0] a, input [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d;
        sel <= wsel;
        @(posedge clk_i);
        while (ack_o !== 1'b1)
            @(posedge clk_i);
        q = dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0;
    endtask
    task sample(input [15:0] v, input [3:0] f);
        @(posedge clk_i);
        src_valid <= 1'b1; src_value <= v; err <= f[0]; over <= f[1]; under <= f[2];
        @(posedge clk_i);
        src_valid <= 1'b0; err <= 1'b0; over <= 1'b0; under <= 1'b0;
    endtask
    // Waits for a state and checks the time it took and what the slave got.
    task wait_state(input x, input integer min_n, input integer max_n);
        n = 0;
        while (out_state_o !== x && n < max_n)
        begin
            @(posedge clk_i);
            n = n + 1;
        end
        check(out_state_o, x);
        check(n >= min_n, 1);
        repeat (2) @(posedge clk_i);
        check(last_value, x ? 16'hffff : 16'h0000);
    endtask

    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    initial
    begin
        repeat (20000) @(posedge clk_i);
        err_count = err_count + 1;
        end_sim;
    end
    // ============================================================
    initial
    begin
        {rst_n_i, cyc_i, stb_i, we_i, src_valid, err, over, under} = 8'h00;
        adr_i = 8'h00; dat_i = 32'h0; src_value = 16'h0; err_count = 0; checks = 0;
        sel = 4'hf;
        wsel = 4'hf;
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        wb(0, `REG_CTRL, 0);       check(q, 0);
        wb(0, `REG_LIST_COUNT, 0); check(q, 0);
        wb(1, `REG_CHAN_INFO, 32'h1234);
        wb(0, `REG_CHAN_INFO, 0);  check(q, 32'h2301_0701);
        wb(0, 8'h40, 0);           check(q, 0);
        wb(1, `REG_LEVEL, 100);
        wsel = 4'h1;
        wb(1, `REG_HYST, 32'hff0a);
        wsel = 4'hf;
        wb(0, `REG_HYST, 0);       check(q, 10);
        wb(1, `REG_CTRL, 32'h100);
        wb(0, `REG_LIST_COUNT, 0); check(q, 3);
        sample(16'h0200, 0); repeat (4) @(posedge clk_i);
        check(out_value_o, 0);
        check(frames, 1);
        wb(0, `REG_OUT_VALUE, 0); check(q, 0);
        wb(1, `REG_CTRL, 32'h101);
        sample(110, 0); repeat (4) @(posedge clk_i); check(out_state_o, 0);
        sample(111, 0); wait_state(1, 0, 4);
        sample(90, 0);  repeat (4) @(posedge clk_i); check(out_state_o, 1);
        sample(89, 0);  wait_state(0, 0, 4);
        wb(1, `REG_HYST, 0);
        wb(1, `REG_LOWER, 50);
        wb(1, `REG_UPPER, 150);
        for (i = 0; i < 6; i = i + 1)
        begin
            e = MODE_TBL[i*16 +: 16];
            wb(1, `REG_CTRL, 32'h100 | e[15:12]);
            sample(e[7:0], 0);
            wait_state(e[8], 0, 4);
        end
        wb(1, `REG_CTRL, 32'h101);
        wb(1, `REG_ON_DELAY, 3);
        wb(1, `REG_OFF_DELAY, 2);
        sample(200, 0); wait_state(1, 6, 30);
        sample(50, 0);  wait_state(0, 3, 30);
        wb(1, `REG_ON_DELAY, 0);
        wb(1, `REG_OFF_DELAY, 0);
        wb(1, `REG_MIN_ON, 4);
        wb(1, `REG_MIN_OFF, 4);
        sample(200, 0); wait_state(1, 0, 30);
        sample(50, 0);  wait_state(0, 8, 30);
        sample(200, 0); wait_state(1, 8, 30);
        wb(1, `REG_MIN_ON, 0);
        wb(1, `REG_MIN_OFF, 0);
        wb(1, `REG_ON_DELAY, 2);
        wb(1, `REG_OFF_DELAY, 2);
        for (i = 0; i < 5; i = i + 1)
        begin
            e = ALARM_TBL[i*16 +: 16];
            wb(1, `REG_CTRL, 32'h101 | (e[15:12] << 4));
            sample(e[8] ? 16'd200 : 16'd50, 0);
            wait_state(e[8], 0, 30);
            sample(16'd300 - out_state_o * 16'd250, e[7:4]);
            wait_state(e[0], e[15:12] >= 3 ? 4 : 0, e[15:12] >= 3 ? 30 : 4);
            wb(0, `REG_STATUS, 0); check(q[2], 1);
            repeat (20) @(posedge clk_i);
            check(out_state_o, e[0]);
        end
        check(frames != 0, 1);
        // A reset in mid-run must bring the channel back to disabled and low.
        rst_n_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        check(out_state_o, 0);
        wb(0, `REG_CTRL, 0);       check(q, 0);
        wb(0, `REG_LIST_COUNT, 0); check(q, 0);
        end_sim;
    end
endmodule // test_threshold_relay_output
